// ==== verilog/rsw_defs.svh ====
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RSW_OFF_CAUSE   12'h000
`define RSW_OFF_DOG     12'h004
`define RSW_OFF_RESTART 12'h008
`define RSW_OFF_REFCTL  12'h00C
// ----------------------------------------
// Field positions, reset values and change-enable window length
// ----------------------------------------
`define RSW_B_DOGF      3
`define RSW_B_UVF       2
`define RSW_B_PINF      1
`define RSW_B_PWRF      0
`define RSW_B_CE        4
`define RSW_B_EN        3
`define RSW_B_BGSEL     0
`define RSW_B_REFON     1
`define RSW_CAUSE_RST   4'h1
`define RSW_CE_WIN      3'h4
// ----------------------------------------
// Timing
// ----------------------------------------
`define RSW_CLK_HZ      10000000
`define RSW_CLK_NS      (1000000000 / `RSW_CLK_HZ)
`define RSW_EXT_MIN_NS  1500
`define RSW_UV_MIN_NS   2000
`define RSW_WDOSC_HZ    1000000
`define RSW_EXT_CYC     (`RSW_EXT_MIN_NS / `RSW_CLK_NS)
`define RSW_UV_CYC      ((`RSW_UV_MIN_NS + `RSW_CLK_NS - 1) / `RSW_CLK_NS)
`define RSW_WD_DIV      (`RSW_CLK_HZ / `RSW_WDOSC_HZ)
`endif

// ==== verilog/rsw_pkg.sv ====
package rsw_pkg;
    typedef enum logic [1:0] {
        RSW_RUN   = 2'b00,
        RSW_HOLD  = 2'b01,
        RSW_DELAY = 2'b10
    } rsw_rst_st_t;

    typedef enum logic [1:0] {
        RSW_LVL0 = 2'b00,
        RSW_LVL1 = 2'b01,
        RSW_LVL2 = 2'b10
    } rsw_lvl_t;

    typedef struct packed {
        logic       en;
        logic [2:0] per;
    } rsw_dog_ctl_t;
endpackage : rsw_pkg

// ==== verilog/rsw_reset_source.sv ====
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rsw_defs.svh"
module rsw_reset_source
    import rsw_pkg::*;
#(
    parameter int unsigned STARTUP_CYC = 4096,
    parameter int unsigned DOG_BASE    = 16384
) (
    // Clock and power-up reset
    input  wire logic        SYS_CLK,
    input  wire logic        SYS_RST,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Pins, detector and fuses (fuse high means programmed)
    input  wire logic        EXT_RESET_N,
    input  wire logic        UV_LOW,
    input  wire logic        UV_THRESHOLD_FUSE,
    input  wire logic        UV_ENABLE_FUSE,
    input  wire logic        COMPAT_FUSE,
    input  wire logic        DOG_ALWAYS_ON_FUSE,
    // Same-domain converter status
    input  wire logic        CONVERTER_EN,
    // Outputs
    output logic             CPU_RST,
    output logic             UV_THRESHOLD_4V0,
    output logic             REF_POWER_ON
);
    localparam logic [4:0] EXT_C = 5'(`RSW_EXT_CYC);
    localparam logic [4:0] UV_C  = 5'(`RSW_UV_CYC);
    localparam logic [3:0] DIV_C = 4'(`RSW_WD_DIV - 1);
    localparam logic [31:0] DLY_C = 32'(STARTUP_CYC - 1);

    function automatic logic [31:0] dog_limit(input logic [2:0] p);
        return 32'(DOG_BASE) << p;
    endfunction : dog_limit

    function automatic rsw_lvl_t safety(input logic cmp, input logic aon);
        if (aon) begin
            return RSW_LVL2;
        end
        return cmp ? RSW_LVL0 : RSW_LVL1;
    endfunction : safety

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [5:0] sync1_ff;
    logic [5:0] sync2_ff;
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1_ff <= 6'h20;
            sync2_ff <= 6'h20;
        end else begin
            sync1_ff <= {EXT_RESET_N, UV_LOW, UV_THRESHOLD_FUSE, UV_ENABLE_FUSE, COMPAT_FUSE, DOG_ALWAYS_ON_FUSE};
            sync2_ff <= sync1_ff;
        end
    end
    logic     pin_n;
    logic     uv_low;
    logic     uv_en;
    rsw_lvl_t lvl;
    assign pin_n  = sync2_ff[5];
    assign uv_low = sync2_ff[4];
    assign uv_en  = sync2_ff[2];
    assign lvl    = safety(sync2_ff[1], sync2_ff[0]);

    // ----------------------------------------
    // Pulse filters
    // ----------------------------------------
    // Pin path is sampled, so a stopped clock cannot see the pin
    logic [4:0] ext_cnt_ff;
    logic [4:0] uv_cnt_ff;
    logic [4:0] nxt_ext_cnt;
    logic [4:0] nxt_uv_cnt;
    logic       ext_act;
    logic       uv_act;
    always_comb begin
        nxt_ext_cnt = pin_n ? 5'h00 : (ext_cnt_ff == EXT_C ? EXT_C : ext_cnt_ff + 5'h01);
        nxt_uv_cnt  = !(uv_low && uv_en) ? 5'h00 : (uv_cnt_ff == UV_C ? UV_C : uv_cnt_ff + 5'h01);
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ext_cnt_ff <= 5'h00;
            uv_cnt_ff  <= 5'h00;
        end else begin
            ext_cnt_ff <= nxt_ext_cnt;
            uv_cnt_ff  <= nxt_uv_cnt;
        end
    end
    assign ext_act = (ext_cnt_ff == EXT_C);
    assign uv_act  = (uv_cnt_ff == UV_C);

    // ----------------------------------------
    // Delay counter and reset output
    // ----------------------------------------
    rsw_rst_st_t st_ff;
    rsw_rst_st_t nxt_st;
    logic [31:0] dly_ff;
    logic [31:0] nxt_dly;
    logic        cpu_rst_ff;
    logic        dog_pulse_ff;
    logic        src;
    assign src = ext_act || uv_act || dog_pulse_ff;
    always_comb begin
        nxt_st  = st_ff;
        nxt_dly = dly_ff;
        unique case (st_ff)
            RSW_RUN: begin
                if (src) begin
                    nxt_st = RSW_HOLD;
                end
            end
            RSW_HOLD: begin
                if (!src) begin
                    nxt_st  = RSW_DELAY;
                    nxt_dly = DLY_C;
                end
            end
            RSW_DELAY: begin
                if (src) begin
                    nxt_st = RSW_HOLD;
                end else if (dly_ff == 32'h0) begin
                    nxt_st = RSW_RUN;
                end else begin
                    nxt_dly = dly_ff - 32'h1;
                end
            end
            default: begin
                nxt_st = RSW_HOLD;
            end
        endcase
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            st_ff      <= RSW_DELAY;
            dly_ff     <= DLY_C;
            cpu_rst_ff <= 1'b1;
        end else begin
            st_ff      <= nxt_st;
            dly_ff     <= nxt_dly;
            cpu_rst_ff <= (nxt_st != RSW_RUN);
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    logic        acc;
    logic        done;
    logic        wr_cause;
    logic        wr_dog;
    logic        wr_restart;
    logic        wr_ref;
    logic        hit;
    logic [31:0] rd;
    logic        pready_ff;
    logic        pslverr_ff;
    logic [31:0] prdata_ff;
    logic [3:0]  flag_ff;
    logic [2:0]  ce_cnt_ff;
    rsw_dog_ctl_t dog_ff;
    logic        dog_on;
    logic        bgsel_ff;
    logic        ref_ff;
    assign acc        = PSEL && PENABLE && !pready_ff;
    assign done       = PSEL && PENABLE && pready_ff && PWRITE;
    assign wr_cause   = done && (PADDR == `RSW_OFF_CAUSE);
    assign wr_dog     = done && (PADDR == `RSW_OFF_DOG);
    assign wr_restart = done && (PADDR == `RSW_OFF_RESTART);
    assign wr_ref     = done && (PADDR == `RSW_OFF_REFCTL);
    always_comb begin
        hit = 1'b1;
        rd  = 32'h0;
        unique case (PADDR)
            `RSW_OFF_CAUSE: rd = {28'h0, flag_ff};
            `RSW_OFF_DOG: rd = {27'h0, ce_cnt_ff != 3'h0, dog_on, dog_ff.per};
            `RSW_OFF_RESTART: rd = 32'h0;
            `RSW_OFF_REFCTL: rd = {30'h0, ref_ff, bgsel_ff};
            default: hit = 1'b0;
        endcase
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= 32'h0;
        end else begin
            pready_ff  <= acc;
            pslverr_ff <= acc && !hit;
            prdata_ff  <= (acc && !PWRITE) ? rd : 32'h0;
        end
    end

    // ----------------------------------------
    // Cause flags
    // ----------------------------------------
    // Internal resets leave the flags alone; only power-up reloads them
    logic [3:0] nxt_flag;
    always_comb begin
        nxt_flag = flag_ff;
        if (wr_cause) begin
            nxt_flag = flag_ff & PWDATA[3:0];
        end
        if (dog_pulse_ff) begin
            nxt_flag[`RSW_B_DOGF] = 1'b1;
        end
        if (uv_act) begin
            nxt_flag[`RSW_B_UVF] = 1'b1;
        end
        if (ext_act) begin
            nxt_flag[`RSW_B_PINF] = 1'b1;
        end
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            flag_ff <= `RSW_CAUSE_RST;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // ----------------------------------------
    // Watchdog control
    // ----------------------------------------
    logic         ce_act;
    logic [2:0]   nxt_ce;
    rsw_dog_ctl_t nxt_dog;
    assign ce_act = (ce_cnt_ff != 3'h0);
    assign dog_on = dog_ff.en || (lvl == RSW_LVL2);
    always_comb begin
        nxt_dog = dog_ff;
        nxt_ce  = ce_act ? ce_cnt_ff - 3'h1 : 3'h0;
        if (cpu_rst_ff) begin
            nxt_dog = '0;
            nxt_ce  = 3'h0;
        end else if (wr_dog) begin
            // Window opens only when enable is written too, so a lone change-enable cannot arm a disable
            if (PWDATA[`RSW_B_CE] && PWDATA[`RSW_B_EN]) begin
                nxt_ce = `RSW_CE_WIN;
            end
            if (PWDATA[`RSW_B_EN]) begin
                nxt_dog.en = 1'b1;
            end else if (ce_act && lvl != RSW_LVL2) begin
                nxt_dog.en = 1'b0;
            end
            if (lvl == RSW_LVL0 || ce_act) begin
                nxt_dog.per = PWDATA[2:0];
            end
        end
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dog_ff    <= '0;
            ce_cnt_ff <= 3'h0;
        end else begin
            dog_ff    <= nxt_dog;
            ce_cnt_ff <= nxt_ce;
        end
    end

    // ----------------------------------------
    // Watchdog counter
    // ----------------------------------------
    // Oscillator is modelled as a divided tick, so its rate tracks SYS_CLK
    logic [3:0]  div_ff;
    logic [3:0]  nxt_div;
    logic [31:0] dcnt_ff;
    logic [31:0] nxt_dcnt;
    logic        nxt_pulse;
    logic        tick;
    assign tick = (div_ff == DIV_C);
    always_comb begin
        nxt_div   = tick ? 4'h0 : div_ff + 4'h1;
        nxt_dcnt  = dcnt_ff;
        nxt_pulse = 1'b0;
        if (cpu_rst_ff || !dog_on || wr_restart) begin
            nxt_dcnt = 32'h0;
        end else if (tick) begin
            if (dcnt_ff == dog_limit(dog_ff.per) - 32'h1) begin
                nxt_dcnt  = 32'h0;
                nxt_pulse = 1'b1;
            end else begin
                nxt_dcnt = dcnt_ff + 32'h1;
            end
        end
    end
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_ff       <= 4'h0;
            dcnt_ff      <= 32'h0;
            dog_pulse_ff <= 1'b0;
        end else begin
            div_ff       <= nxt_div;
            dcnt_ff      <= nxt_dcnt;
            dog_pulse_ff <= nxt_pulse;
        end
    end

    // ----------------------------------------
    // Reference and threshold
    // ----------------------------------------
    logic uvth_ff;
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            bgsel_ff <= 1'b0;
            ref_ff   <= 1'b0;
            uvth_ff  <= 1'b0;
        end else begin
            bgsel_ff <= wr_ref ? PWDATA[`RSW_B_BGSEL] : bgsel_ff;
            ref_ff   <= uv_en || bgsel_ff || CONVERTER_EN;
            uvth_ff  <= sync2_ff[3];
        end
    end

    assign PRDATA           = prdata_ff;
    assign PREADY           = pready_ff;
    assign PSLVERR          = pslverr_ff;
    assign CPU_RST          = cpu_rst_ff;
    assign UV_THRESHOLD_4V0 = uvth_ff;
    assign REF_POWER_ON     = ref_ff;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);

    property p_pin_reset;
        $rose(ext_act) |-> !$past(pin_n) ##1 (cpu_rst_ff && flag_ff[`RSW_B_PINF]);
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin reset not taken");

    property p_hold_delay;
        (st_ff == RSW_HOLD && !src) |=> (st_ff == RSW_DELAY && cpu_rst_ff)[*4];
    endproperty
    a_hold_delay: assert property (p_hold_delay) else $error("reset released early");

    property p_uv_fuse;
        !uv_en |-> !uv_act;
    endproperty
    a_uv_fuse: assert property (p_uv_fuse) else $error("undervoltage reset without fuse");

    property p_uv_min;
        $rose(uv_act) |-> $past(uv_low && uv_en, 1) && $past(uv_cnt_ff) == UV_C - 5'h01;
    endproperty
    a_uv_min: assert property (p_uv_min) else $error("short undervoltage accepted");

    property p_dog_pulse;
        dog_pulse_ff |=> !dog_pulse_ff ##0 cpu_rst_ff ##0 flag_ff[`RSW_B_DOGF] ##1 st_ff == RSW_DELAY;
    endproperty
    a_dog_pulse: assert property (p_dog_pulse) else $error("watchdog pulse malformed");

    property p_pwr_flag;
        $fell(flag_ff[`RSW_B_PWRF]) |-> $past(wr_cause && !PWDATA[`RSW_B_PWRF]);
    endproperty
    a_pwr_flag: assert property (p_pwr_flag) else $error("power-up flag lost");

    property p_ref;
        (uv_en || bgsel_ff) |=> REF_POWER_ON;
    endproperty
    a_ref: assert property (p_ref) else $error("reference not powered");

    property p_restart;
        wr_restart |=> dcnt_ff == 32'h0 && !dog_pulse_ff;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear");

    property p_lvl2;
        lvl == RSW_LVL2 |-> dog_on;
    endproperty
    a_lvl2: assert property (p_lvl2) else $error("level 2 watchdog off");

    property p_enable;
        (wr_dog && PWDATA[`RSW_B_EN] && !cpu_rst_ff) |=> dog_on;
    endproperty
    a_enable: assert property (p_enable) else $error("single-write enable failed");

    property p_ce_window;
        (wr_dog && PWDATA[`RSW_B_CE] && !cpu_rst_ff) ##1 !wr_dog[*4] |=> !ce_act;
    endproperty
    a_ce_window: assert property (p_ce_window) else $error("change enable not cleared");
endmodule : rsw_reset_source

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
`include "rsw_defs.svh"
module tb_top;
    // ----------------------------------------
    // Bench signals
    // ----------------------------------------
    localparam int STARTUP = 20;
    localparam int LIMIT   = 20000;
    logic        sys_clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_reset_n;
    logic        uv_low;
    logic        uv_thr;
    logic        uv_en;
    logic        compat;
    logic        aon;
    logic        conv_en;
    logic        cpu_rst;
    logic        thr_4v0;
    logic        ref_on;
    int          errors          = 0;
    int          samples_checked = 0;
    int          cycles          = 0;

    rsw_reset_source #(
        .STARTUP_CYC (STARTUP),
        .DOG_BASE    (4)
    ) i_rsw_reset_source (
        .SYS_CLK            (sys_clk),
        .SYS_RST            (sys_rst),
        .PSEL               (psel),
        .PENABLE            (penable),
        .PWRITE             (pwrite),
        .PADDR              (paddr),
        .PWDATA             (pwdata),
        .PRDATA             (prdata),
        .PREADY             (pready),
        .PSLVERR            (pslverr),
        .EXT_RESET_N        (ext_reset_n),
        .UV_LOW             (uv_low),
        .UV_THRESHOLD_FUSE  (uv_thr),
        .UV_ENABLE_FUSE     (uv_en),
        .COMPAT_FUSE        (compat),
        .DOG_ALWAYS_ON_FUSE (aon),
        .CONVERTER_EN       (conv_en),
        .CPU_RST            (cpu_rst),
        .UV_THRESHOLD_4V0   (thr_4v0),
        .REF_POWER_ON       (ref_on)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tally_and_finish();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Chained calls keep psel up so a second write lands inside short windows
    task automatic apb(input logic dir, input logic [11:0] a, input logic [31:0] d, input logic chain,
                       output logic [31:0] r, output logic e);
        int n;
        if (psel !== 1'b1) psel <= 1'b1;
        pwrite <= dir;
        paddr  <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        r = prdata;
        e = pslverr;
        chk("pready", 32'(pready), 1);
        penable <= 1'b0;
        if (!chain) begin
            psel <= 1'b0;
            @(posedge sys_clk);
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic chain);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, chain, r, e);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr, input string nm);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 1'b0, r, e);
        chk(nm, r, exp);
        chk("pslverr", 32'(e), 32'(experr));
    endtask : rd

    task automatic wait_lvl(input logic want, input int lo, input int hi, input string nm);
        int n;
        n = 0;
        while (cpu_rst !== want && n < hi) begin
            @(posedge sys_clk);
            n++;
        end
        chk(nm, 32'(n >= lo && cpu_rst === want), 1);
    endtask : wait_lvl

    task automatic quiet(input int n, input string nm);
        logic bad;
        bad = 1'b0;
        repeat (n) begin
            @(posedge sys_clk);
            if (cpu_rst !== 1'b0) bad = 1'b1;
        end
        chk(nm, 32'(bad), 0);
    endtask : quiet

    // Fuses only change under power-up reset, as on silicon
    task automatic pwr(input logic t, input logic en, input logic c, input logic a);
        uv_thr  <= t;
        uv_en   <= en;
        compat  <= c;
        aon     <= a;
        sys_rst <= 1'b1;
        repeat (8) @(posedge sys_clk);
        chk("rst_hold", 32'(cpu_rst), 1);
        sys_rst <= 1'b0;
        wait_lvl(1'b0, STARTUP, STARTUP + 10, "startup");
        chk("thr_4v0", 32'(thr_4v0), 32'(t));
        chk("ref_on", 32'(ref_on), 32'(en));
        rd(`RSW_OFF_CAUSE, 32'h1, 1'b0, "cause_pwr");
    endtask : pwr

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        ext_reset_n = 1'b1;
        uv_low = 1'b0;
        conv_en = 1'b0;
        pwr(1'b0, 1'b0, 1'b0, 1'b0);
        rd(12'h010, 32'h0, 1'b1, "unmapped");
        wr(`RSW_OFF_REFCTL, 32'h1, 1'b0);
        rd(`RSW_OFF_REFCTL, 32'h3, 1'b0, "refctl");
        wr(`RSW_OFF_REFCTL, 32'h0, 1'b0);
        conv_en <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("ref_conv", 32'(ref_on), 1);
        conv_en <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("ref_off", 32'(ref_on), 0);
        uv_low <= 1'b1;
        quiet(40, "uv_nofuse");
        uv_low <= 1'b0;
        ext_reset_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        ext_reset_n <= 1'b1;
        quiet(30, "pin_short");
        ext_reset_n <= 1'b0;
        wait_lvl(1'b1, 14, 24, "pin_rst");
        repeat (5) @(posedge sys_clk);
        ext_reset_n <= 1'b1;
        wait_lvl(1'b0, STARTUP, STARTUP + 8, "pin_delay");
        rd(`RSW_OFF_CAUSE, 32'h3, 1'b0, "cause_pin");
        wr(`RSW_OFF_CAUSE, 32'h2, 1'b0);
        rd(`RSW_OFF_CAUSE, 32'h2, 1'b0, "cause_clr");
        // Level 1: enable is free, disable and period need the window
        rd(`RSW_OFF_DOG, 32'h00, 1'b0, "l1_init");
        wr(`RSW_OFF_DOG, 32'h0A, 1'b0);
        rd(`RSW_OFF_DOG, 32'h08, 1'b0, "l1_en");
        wr(`RSW_OFF_DOG, 32'h18, 1'b1);
        wr(`RSW_OFF_DOG, 32'h00, 1'b0);
        rd(`RSW_OFF_DOG, 32'h00, 1'b0, "l1_off");
        wr(`RSW_OFF_DOG, 32'h08, 1'b0);
        wr(`RSW_OFF_DOG, 32'h00, 1'b0);
        rd(`RSW_OFF_DOG, 32'h08, 1'b0, "l1_nowin");
        wr(`RSW_OFF_DOG, 32'h18, 1'b1);
        wr(`RSW_OFF_DOG, 32'h0B, 1'b0);
        rd(`RSW_OFF_DOG, 32'h0B, 1'b0, "l1_per");
        wr(`RSW_OFF_DOG, 32'h10, 1'b1);
        wr(`RSW_OFF_DOG, 32'h00, 1'b0);
        rd(`RSW_OFF_DOG, 32'h0B, 1'b0, "l1_ceonly");
        wr(`RSW_OFF_DOG, 32'h1B, 1'b0);
        repeat (4) @(posedge sys_clk);
        wr(`RSW_OFF_DOG, 32'h02, 1'b0);
        rd(`RSW_OFF_DOG, 32'h0B, 1'b0, "l1_late");
        // Undervoltage with the detector fused on
        pwr(1'b1, 1'b1, 1'b0, 1'b0);
        uv_low <= 1'b1;
        repeat (10) @(posedge sys_clk);
        uv_low <= 1'b0;
        quiet(30, "uv_short");
        uv_low <= 1'b1;
        wait_lvl(1'b1, 18, 30, "uv_rst");
        repeat (5) @(posedge sys_clk);
        uv_low <= 1'b0;
        wait_lvl(1'b0, STARTUP, STARTUP + 8, "uv_delay");
        rd(`RSW_OFF_CAUSE, 32'h5, 1'b0, "cause_uv");
        // Level 0: free period change, restart keeps the dog quiet
        pwr(1'b0, 1'b0, 1'b1, 1'b0);
        rd(`RSW_OFF_DOG, 32'h00, 1'b0, "l0_init");
        wr(`RSW_OFF_DOG, 32'h09, 1'b0);
        rd(`RSW_OFF_DOG, 32'h09, 1'b0, "l0_per");
        repeat (5) begin
            quiet(25, "kick");
            wr(`RSW_OFF_RESTART, 32'h1, 1'b0);
        end
        wait_lvl(1'b1, 70, 100, "dog_per1");
        wait_lvl(1'b0, STARTUP, STARTUP + 10, "dog_delay");
        rd(`RSW_OFF_CAUSE, 32'h9, 1'b0, "cause_dog");
        wr(`RSW_OFF_CAUSE, 32'h0, 1'b0);
        rd(`RSW_OFF_CAUSE, 32'h0, 1'b0, "cause_zero");
        rd(`RSW_OFF_DOG, 32'h00, 1'b0, "dog_cleared");
        // Level 2: starts enabled and cannot be turned off
        pwr(1'b0, 1'b0, 1'b0, 1'b1);
        rd(`RSW_OFF_DOG, 32'h08, 1'b0, "l2_init");
        wr(`RSW_OFF_DOG, 32'h18, 1'b1);
        wr(`RSW_OFF_DOG, 32'h00, 1'b0);
        rd(`RSW_OFF_DOG, 32'h08, 1'b0, "l2_stuck");
        wr(`RSW_OFF_RESTART, 32'h1, 1'b0);
        wait_lvl(1'b1, 25, 50, "dog_per0");
        wait_lvl(1'b0, STARTUP, STARTUP + 10, "dog_delay2");
        rd(`RSW_OFF_CAUSE, 32'h9, 1'b0, "cause_dog2");
        pwr(1'b0, 1'b0, 1'b1, 1'b1);
        rd(`RSW_OFF_DOG, 32'h08, 1'b0, "l2_both");
        tally_and_finish();
    end
endmodule : tb_top
